// File: bench/sensor_sync_bench.sv
// self-checking bench of the sampling trigger block
`timescale 1ns/100ps
module sensor_sync_bench;
  localparam int unsigned LOOPS = 20;
  logic                    clk, rst, awvalid, wvalid, bready, arvalid, rready, att;
  logic [5:0]              awaddr, araddr;
  logic [31:0]             wdata, rd;
  logic [3:0]              wstrb;
  logic [1:0]              rsp;
  wire logic               awready, wready, arready, bvalid, rvalid, samp, lstart, magv, trig;
  wire logic [1:0]         bresp, rresp;
  wire logic [31:0]        rdata;
  wire logic [15:0]        step;
  sensor_sync_pkg::meas_s  int_meas;
  wire sensor_sync_pkg::meas_s filt;
  int                      bad_count, checks_done, n_loop, n_samp, n_both;

  sensor_sync #(.LOOP_CYCLES(LOOPS)) sensor_sync_inst (
    .CLK_IN(clk), .RST_IN(rst), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .AWADDR_IN(awaddr),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .BRESP_OUT(bresp), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .ARADDR_IN(araddr), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .TRIGGER_PULSE_IN(trig), .ATT_READY_IN(att),
    .INT_MEAS_IN(int_meas), .SAMPLE_PULSE_OUT(samp), .LOOP_START_OUT(lstart),
    .FILT_MEAS_OUT(filt), .MAG_VALID_OUT(magv), .LOOP_STEP_US_OUT(step));
  trigger_source trigger_source_inst (.clk_in(clk), .trig_out(trig));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulse counters, read on the quiet edge
  always @(negedge clk) begin
    n_loop += int'(lstart);
    n_samp += int'(samp);
    n_both += int'(samp && lstart);
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict and shared checks
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // bus cycles and loop waits
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (i == 50) give_up();
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [5:0] a);
    int i;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && !arready) continue;
      arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (i == 50) give_up();
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_loop();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (lstart) break;
    end
    if (i == 200) give_up();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_reset();
    rdr(sensor_sync_pkg::SYNC_CTRL_OFF);
    check(rd, 32'h00000002);
    wr(sensor_sync_pkg::STEP_OFF, 32'h00000001);
    check({30'h0, rsp}, {30'h0, sensor_sync_pkg::RESP_OKAY});
    rdr(sensor_sync_pkg::STEP_OFF);
    check(rd, 32'h00001388);
    check({16'h0000, step}, 32'h00001388);
    rdr(6'h28);
    check({30'h0, rsp}, {30'h0, sensor_sync_pkg::RESP_SLVERR});
    check(rd, 32'h00000000);
    wr(6'h28, 32'h00000001);
    check({30'h0, rsp}, {30'h0, sensor_sync_pkg::RESP_SLVERR});
  endtask
  task automatic s_internal();
    int c;
    wait_loop();
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (!lstart && c < 200);
    check(32'(c), 32'(LOOPS));
  endtask
  task automatic s_modes();
    int a, s, b;
    for (int m = 0; m < 3; m++) begin
      wr(sensor_sync_pkg::SYNC_CTRL_OFF, 32'(m));
      a = n_loop;
      s = n_samp;
      b = n_both;
      @(posedge clk);
      att <= 1'b1;
      @(posedge clk);
      att <= 1'b0;
      repeat (LOOPS + 2) @(posedge clk);
      check(32'(n_samp - s), m == 0 ? 32'h0 : m == 1 ? 32'(n_loop - a) : 32'h1);
      if (m == 1) check(32'(n_both - b), 32'(n_samp - s));
    end
  endtask
  task automatic s_sources();
    wr(sensor_sync_pkg::MEAS_OFF, 32'hdead0001);
    rdr(sensor_sync_pkg::MEAS_OFF);
    check(rd, int_meas.mag[0]);
    wr(sensor_sync_pkg::FILT_CTRL_OFF, 32'h00000001);
    wr(sensor_sync_pkg::MEAS_OFF, 32'h0a0a0001);
    wr(6'h14, 32'hdead0002);
    wait_loop();
    check(filt.mag[0], 32'h0a0a0001);
    check(filt.acc[0], int_meas.acc[0]);
    wait_loop();
    check(filt.mag[0], 32'h0a0a0001);
    check({31'h0, magv}, 32'h00000001);
    wr(sensor_sync_pkg::FILT_CTRL_OFF, 32'h00000010);
    wr(6'h14, 32'h0b0b0002);
    wait_loop();
    check(filt.acc[0], 32'h0b0b0002);
    check(filt.mag[0], int_meas.mag[0]);
  endtask
  task automatic s_fresh();
    wr(sensor_sync_pkg::FILT_CTRL_OFF, 32'h00000002);
    wait_loop();
    wr(sensor_sync_pkg::MEAS_OFF, 32'h0c0c0003);
    rdr(sensor_sync_pkg::STATUS_OFF);
    check({31'h0, rd[0]}, 32'h00000001);
    wait_loop();
    check({31'h0, magv}, 32'h00000001);
    check(filt.mag[0], 32'h0c0c0003);
    rdr(sensor_sync_pkg::STATUS_OFF);
    check({31'h0, rd[0]}, 32'h00000000);
    wait_loop();
    check({31'h0, magv}, 32'h00000000);
  endtask
  task automatic s_external();
    int a, b;
    wr(sensor_sync_pkg::SYNC_CTRL_OFF, 32'h00000411);
    a = n_loop;
    b = n_both;
    trigger_source_inst.send(10, 3);
    repeat (4) @(posedge clk);
    check(32'(n_loop - a), 32'h00000002);
    check(32'(n_both - b), 32'h00000002);
    wr(sensor_sync_pkg::SYNC_CTRL_OFF, 32'h00000031);
    a = n_loop;
    b = n_both;
    trigger_source_inst.send(3, 3);
    repeat (4) @(posedge clk);
    check(32'(n_loop - a), 32'h00000003);
    check(32'(n_both - b), 32'h00000003);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset, then each scenario in turn
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, att} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 48'h0;
    for (int i = 0; i < 3; i++) begin
      int_meas.mag[i] = 32'h10000000 + 32'(i);
      int_meas.acc[i] = 32'h20000000 + 32'(i);
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    s_reset();
    s_internal();
    s_modes();
    s_sources();
    s_fresh();
    s_external();
    final_report();
  end
endmodule // sensor_sync_bench

// File: bench/trigger_source.sv
// trigger pulse source standing in for an outside timing master
`timescale 1ns/100ps
module trigger_source (
  input  wire logic clk_in,  // bench clock
  output logic      trig_out // drives the trigger input
);
  // line rests low between bursts
  initial trig_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // burst of even pulses
  task automatic send(input int pulses, input int half);
    for (int p = 0; p < pulses; p++) begin
      repeat (half) @(posedge clk_in);
      trig_out <= 1'b1;
      repeat (half) @(posedge clk_in);
      trig_out <= 1'b0;
    end
  endtask
endmodule // trigger_source

// File: common/sensor_sync_pkg.sv
// constants, enums and structs of the sampling trigger block
package sensor_sync_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned LOOP_HZ       = 200;
  localparam int unsigned LOOP_STEP_US  = 5000;
  localparam int unsigned LOOP_CYCLES   = CLK_HZ / LOOP_HZ;
  localparam int unsigned TICK_W        = 17;
  localparam int unsigned DIV_W         = 8;
  // register byte offsets
  localparam logic [5:0] SYNC_CTRL_OFF  = 6'h00;
  localparam logic [5:0] FILT_CTRL_OFF  = 6'h04;
  localparam logic [5:0] MEAS_OFF       = 6'h08;
  localparam logic [5:0] STATUS_OFF     = 6'h20;
  localparam logic [5:0] STEP_OFF       = 6'h24;
  localparam logic [3:0] MEAS_WORDS     = 4'h6;
  // field positions
  localparam int unsigned SC_MODE_LSB   = 0;
  localparam int unsigned SC_EXT_BIT    = 4;
  localparam int unsigned SC_FALL_BIT   = 5;
  localparam int unsigned SC_DIV_LSB    = 8;
  localparam int unsigned FC_MAG_LSB    = 0;
  localparam int unsigned FC_ACC_LSB    = 4;
  localparam int unsigned ST_LOOP_LSB   = 16;
  // bus responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    SYNC_OFF      = 2'b00,
    SYNC_SAMPLE   = 2'b01,
    SYNC_ATTITUDE = 2'b10
  } sync_mode_e;

  typedef enum logic [1:0] {
    SRC_INTERNAL  = 2'b00,
    SRC_EXTERNAL  = 2'b01,
    SRC_FRESH     = 2'b10
  } src_e;

  localparam sync_mode_e SYNC_MODE_RST = SYNC_ATTITUDE;

  typedef struct packed {
    logic [2:0][31:0] mag;
    logic [2:0][31:0] acc;
  } meas_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              aw_ok;
    logic              w_ok;
    logic              bvalid;
    logic              rvalid;
    logic [5:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    sync_mode_e        sync_mode;
    logic              ext_time;
    logic              fall_edge;
    logic [DIV_W-1:0]  divider;
    src_e              mag_sel;
    src_e              acc_sel;
    meas_s             ext_meas;
    meas_s             filt_meas;
    logic              fresh_mag;
    logic              fresh_acc;
    logic              mag_valid;
    logic              trig_prev;
    logic              sample_pulse;
    logic              loop_start;
    logic [DIV_W-1:0]  edge_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic [15:0]       loop_cnt;
    logic [15:0]       step_us;
  } state_s;
endpackage

// File: rtl/sensor_sync.sv
// sampling trigger, sync pulse and external sensor slots
//
// Contract
// RULE1 - as timing master the sync output pulses when each sampling cycle begins.
// RULE2 - as timing slave sampling starts on the selected edge of the trigger input.
// RULE3 - master and slaves sample together, each slave following the master pulse.
// RULE4 - with no external timing the loop runs from the internal clock at 200 Hz.
// RULE5 - the integration step is always a fixed 5 ms per loop.
// RULE6 - with external timing the trigger input drives sampling and loop, not the clock.
// RULE7 - the outside source delivers 200 Hz of triggers, possibly as a multiple.
// RULE8 - a trigger fires on every divider-plus-one selected edges.
// RULE9 - magnetometer and accelerometer each pick internal or external data.
// RULE10 - the measurement words are writable only for an externally sourced quantity.
// RULE11 - words of internally sourced quantities ignore writes and keep their values.
// RULE12 - the measurement words are latched at the start of every loop.
// RULE13 - a stale external magnetometer value keeps being used until rewritten.
// RULE14 - with magnetometer select 2 its data is used only in loops after a new write.
// RULE15 - the sync output pulses on attitude ready by default, or on new samples.
// RULE16 - a write to an external quantity sets a fresh flag cleared by the next latch.
`timescale 1ns/100ps
module sensor_sync #(
  parameter int unsigned LOOP_CYCLES = sensor_sync_pkg::LOOP_CYCLES
) (
  input  wire logic                   CLK_IN,           // 20 MHz clock
  input  wire logic                   RST_IN,           // sync reset, high
  input  wire logic                   AWVALID_IN,       // write address valid
  output logic                        AWREADY_OUT,      // write address ready
  input  wire logic [5:0]             AWADDR_IN,        // write byte address
  input  wire logic                   WVALID_IN,        // write data valid
  output logic                        WREADY_OUT,       // write data ready
  input  wire logic [31:0]            WDATA_IN,         // write data
  input  wire logic [3:0]             WSTRB_IN,         // byte enables
  output logic                        BVALID_OUT,       // write response valid
  input  wire logic                   BREADY_IN,        // write response ready
  output logic [1:0]                  BRESP_OUT,        // write response
  input  wire logic                   ARVALID_IN,       // read address valid
  output logic                        ARREADY_OUT,      // read address ready
  input  wire logic [5:0]             ARADDR_IN,        // read byte address
  output logic                        RVALID_OUT,       // read data valid
  input  wire logic                   RREADY_IN,        // read data ready
  output logic [31:0]                 RDATA_OUT,        // read data
  output logic [1:0]                  RRESP_OUT,        // read response
  input  wire logic                   TRIGGER_PULSE_IN, // external sync input
  input  wire logic                   ATT_READY_IN,     // attitude result pulse
  input  wire sensor_sync_pkg::meas_s INT_MEAS_IN,      // internal sensor words
  output logic                        SAMPLE_PULSE_OUT, // sync output pulse
  output logic                        LOOP_START_OUT,   // converter/loop start
  output sensor_sync_pkg::meas_s      FILT_MEAS_OUT,    // latched filter inputs
  output logic                        MAG_VALID_OUT,    // magnetometer usable
  output logic [15:0]                 LOOP_STEP_US_OUT  // integration step
);

  ////////////////////////////////////////////////////////////////////////////
  // state and views

  // tick counter width, needed before the loop compare
  localparam int unsigned TICK_W = sensor_sync_pkg::TICK_W;

  sensor_sync_pkg::state_s st_r;
  sensor_sync_pkg::state_s st_nxt;
  sensor_sync_pkg::meas_s  view;
  logic                    mag_ext;
  logic                    acc_ext;
  logic                    edge_seen;
  logic                    fire;
  logic                    loop_go;
  logic                    wr_go;
  logic                    wr_mag;
  logic                    wr_acc;

  // external select per quantity
  // RULE9 source choice per quantity
  assign mag_ext = (st_r.mag_sel == sensor_sync_pkg::SRC_EXTERNAL) ||
                   (st_r.mag_sel == sensor_sync_pkg::SRC_FRESH);
  assign acc_ext = (st_r.acc_sel == sensor_sync_pkg::SRC_EXTERNAL) ||
                   (st_r.acc_sel == sensor_sync_pkg::SRC_FRESH);

  // measurement words as seen by bus and latch
  for (genvar i = 0; i < 3; i++) begin : g_view
    assign view.mag[i] = mag_ext ? st_r.ext_meas.mag[i] : INT_MEAS_IN.mag[i];
    assign view.acc[i] = acc_ext ? st_r.ext_meas.acc[i] : INT_MEAS_IN.acc[i];
  end

  // selected edge on trigger input
  assign edge_seen = st_r.fall_edge ? (st_r.trig_prev && !TRIGGER_PULSE_IN)
                                    : (!st_r.trig_prev && TRIGGER_PULSE_IN);
  // RULE8 divider plus one edges
  assign fire = st_r.ext_time && edge_seen && (st_r.edge_cnt == st_r.divider);
  // RULE4 internal tick else RULE6 external trigger
  assign loop_go = st_r.ext_time ? fire
                 : (st_r.tick_cnt == TICK_W'(LOOP_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // register read view by byte address
  function automatic logic [32:0] rd_word(input logic [5:0] a);
    logic [32:0] r;
    logic [3:0]  m;
    r = 33'h0;
    m = a[5:2] - sensor_sync_pkg::MEAS_OFF[5:2];
    case (a)
      sensor_sync_pkg::SYNC_CTRL_OFF: begin
        r[32] = 1'b1;
        r[sensor_sync_pkg::SC_MODE_LSB +: 2] = st_r.sync_mode;
        r[sensor_sync_pkg::SC_EXT_BIT] = st_r.ext_time;
        r[sensor_sync_pkg::SC_FALL_BIT] = st_r.fall_edge;
        r[sensor_sync_pkg::SC_DIV_LSB +: sensor_sync_pkg::DIV_W] = st_r.divider;
      end
      sensor_sync_pkg::FILT_CTRL_OFF: begin
        r[32] = 1'b1;
        r[sensor_sync_pkg::FC_MAG_LSB +: 2] = st_r.mag_sel;
        r[sensor_sync_pkg::FC_ACC_LSB +: 2] = st_r.acc_sel;
      end
      sensor_sync_pkg::STATUS_OFF: begin
        r[32] = 1'b1;
        r[2:0] = {st_r.mag_valid, st_r.fresh_acc, st_r.fresh_mag};
        r[sensor_sync_pkg::ST_LOOP_LSB +: 16] = st_r.loop_cnt;
      end
      sensor_sync_pkg::STEP_OFF: begin
        r[32] = 1'b1;
        r[15:0] = st_r.step_us;
      end
      default: begin
        if (a[1:0] == 2'h0 && a >= sensor_sync_pkg::MEAS_OFF && m < sensor_sync_pkg::MEAS_WORDS) begin
          r[32] = 1'b1;
          r[31:0] = (m < 4'h3) ? view.mag[m[1:0]] : view.acc[2'(m - 4'h3)];
        end
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [32:0] cur;
    logic [31:0] wv;
    logic [3:0]  m;
    cur = 33'h0;
    wv = 32'h0;
    m = 4'h0;
    wr_mag = 1'b0;
    wr_acc = 1'b0;
    st_nxt = st_r;
    st_nxt.trig_prev = TRIGGER_PULSE_IN;
    st_nxt.step_us = 16'(sensor_sync_pkg::LOOP_STEP_US);

    // write address and data, either order
    if (AWVALID_IN && st_r.awready) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.aw_addr = AWADDR_IN;
    end
    if (WVALID_IN && st_r.wready) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.w_data = WDATA_IN;
      st_nxt.w_strb = WSTRB_IN;
    end

    // register write
    wr_go = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
    if (wr_go) begin
      cur = rd_word(st_r.aw_addr);
      wv = merge(cur[31:0], st_r.w_data, st_r.w_strb);
      m = st_r.aw_addr[5:2] - sensor_sync_pkg::MEAS_OFF[5:2];
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = cur[32] ? sensor_sync_pkg::RESP_OKAY : sensor_sync_pkg::RESP_SLVERR;
      case (st_r.aw_addr)
        sensor_sync_pkg::SYNC_CTRL_OFF: begin
          st_nxt.sync_mode = sensor_sync_pkg::sync_mode_e'(wv[sensor_sync_pkg::SC_MODE_LSB +: 2]);
          st_nxt.ext_time = wv[sensor_sync_pkg::SC_EXT_BIT];
          st_nxt.fall_edge = wv[sensor_sync_pkg::SC_FALL_BIT];
          st_nxt.divider = wv[sensor_sync_pkg::SC_DIV_LSB +: sensor_sync_pkg::DIV_W];
        end
        sensor_sync_pkg::FILT_CTRL_OFF: begin
          st_nxt.mag_sel = sensor_sync_pkg::src_e'(wv[sensor_sync_pkg::FC_MAG_LSB +: 2]);
          st_nxt.acc_sel = sensor_sync_pkg::src_e'(wv[sensor_sync_pkg::FC_ACC_LSB +: 2]);
        end
        default: begin
          // RULE10 writable only when external
          // RULE11 other words keep their value
          if (cur[32] && m < 4'h3 && mag_ext) begin
            st_nxt.ext_meas.mag[m[1:0]] = wv;
            wr_mag = 1'b1;
          end else if (cur[32] && m >= 4'h3 && m < sensor_sync_pkg::MEAS_WORDS && acc_ext) begin
            st_nxt.ext_meas.acc[2'(m - 4'h3)] = wv;
            wr_acc = 1'b1;
          end
        end
      endcase
    end
    if (st_r.bvalid && BREADY_IN) begin
      st_nxt.bvalid = 1'b0;
    end

    // register read
    if (ARVALID_IN && st_r.arready) begin
      cur = rd_word(ARADDR_IN);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = cur[31:0];
      st_nxt.rresp = cur[32] ? sensor_sync_pkg::RESP_OKAY : sensor_sync_pkg::RESP_SLVERR;
    end
    if (st_r.rvalid && RREADY_IN) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_ok;
    st_nxt.wready = !st_nxt.w_ok;
    st_nxt.arready = !st_nxt.rvalid;

    // internal 200 Hz tick, held at zero under external timing
    // RULE4 fixed internal rate
    if (st_r.ext_time || loop_go) begin
      st_nxt.tick_cnt = '0;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end

    // edge divider
    // RULE8 count selected edges
    if (!st_r.ext_time || fire) begin
      st_nxt.edge_cnt = '0;
    end else if (edge_seen) begin
      st_nxt.edge_cnt = st_r.edge_cnt + 1'b1;
    end

    // RULE16 fresh flags, set wins over clear
    if (loop_go) begin
      st_nxt.fresh_mag = 1'b0;
      st_nxt.fresh_acc = 1'b0;
    end
    if (wr_mag) begin
      st_nxt.fresh_mag = 1'b1;
    end
    if (wr_acc) begin
      st_nxt.fresh_acc = 1'b1;
    end

    // loop start latch
    // RULE12 latch at loop start
    // RULE13 stored value reused
    // RULE14 mode 2 uses fresh data only
    st_nxt.loop_start = loop_go;
    if (loop_go) begin
      st_nxt.filt_meas = view;
      st_nxt.mag_valid = (st_r.mag_sel == sensor_sync_pkg::SRC_FRESH) ? st_r.fresh_mag : 1'b1;
      st_nxt.loop_cnt = st_r.loop_cnt + 1'b1;
    end

    // sync output source
    // RULE1 pulse at sampling start
    // RULE15 attitude or sample source
    case (st_r.sync_mode)
      sensor_sync_pkg::SYNC_SAMPLE:   st_nxt.sample_pulse = loop_go;
      sensor_sync_pkg::SYNC_ATTITUDE: st_nxt.sample_pulse = ATT_READY_IN;
      default:                        st_nxt.sample_pulse = 1'b0;
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_r <= '0;
      st_r.sync_mode <= sensor_sync_pkg::SYNC_MODE_RST;
      st_r.step_us <= 16'(sensor_sync_pkg::LOOP_STEP_US);
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // all straight from the state register
  // RULE5 fixed step
  assign LOOP_STEP_US_OUT = st_r.step_us;
  assign AWREADY_OUT = st_r.awready;
  assign WREADY_OUT = st_r.wready;
  assign BVALID_OUT = st_r.bvalid;
  assign BRESP_OUT = st_r.bresp;
  assign ARREADY_OUT = st_r.arready;
  assign RVALID_OUT = st_r.rvalid;
  assign RDATA_OUT = st_r.rdata;
  assign RRESP_OUT = st_r.rresp;
  // RULE2 converter start on trigger
  // RULE3 same edge as master pulse
  assign LOOP_START_OUT = st_r.loop_start;
  assign SAMPLE_PULSE_OUT = st_r.sample_pulse;
  assign FILT_MEAS_OUT = st_r.filt_meas;
  assign MAG_VALID_OUT = st_r.mag_valid;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_internal_tick: assert property ( // RULE4
    (!st_r.ext_time && st_r.tick_cnt == TICK_W'(LOOP_CYCLES - 1)) |=> st_r.loop_start)
    else $error("internal loop tick missed");

  a_ext_fire_start: assert property ( // RULE6
    (st_r.ext_time && !fire) |=> !st_r.loop_start)
    else $error("loop started without trigger");

  a_edge_divide: assert property ( // RULE8
    (fire ##1 (st_r.ext_time && st_r.divider == $past(st_r.divider))) |-> st_r.edge_cnt == '0)
    else $error("edge divider not restarted");

  a_edge_count: assert property ( // RULE8
    (st_r.ext_time && edge_seen && !fire) |=> st_r.edge_cnt == $past(st_r.edge_cnt) + 1'b1)
    else $error("selected edge not counted");

  a_master_pulse: assert property ( // RULE1
    (st_r.sync_mode == sensor_sync_pkg::SYNC_SAMPLE && loop_go) |=> (st_r.sample_pulse && st_r.loop_start))
    else $error("sync pulse not with sampling start");

  a_step_fixed: assert property ( // RULE5
    LOOP_STEP_US_OUT == 16'(sensor_sync_pkg::LOOP_STEP_US))
    else $error("integration step changed");

  a_ro_kept: assert property ( // RULE11
    (wr_go && !mag_ext) |=> st_r.ext_meas.mag == $past(st_r.ext_meas.mag))
    else $error("read-only magnetometer word changed");

  a_fresh_only: assert property ( // RULE14
    (loop_go && st_r.mag_sel == sensor_sync_pkg::SRC_FRESH) |=> st_r.mag_valid == $past(st_r.fresh_mag))
    else $error("fresh-only magnetometer use wrong");

  a_fresh_clear: assert property ( // RULE16
    (loop_go && !wr_mag) |=> !st_r.fresh_mag)
    else $error("fresh flag not consumed");

  a_latch_ext: assert property ( // RULE12
    (loop_go && mag_ext) |=> st_r.filt_meas.mag == $past(st_r.ext_meas.mag))
    else $error("external magnetometer not latched");

endmodule // sensor_sync
